// >>> pkg/suptu_consts.svh
// Constants of the supervisor trap unit: CSR addresses, field positions, codes.
// Assumes a 64-bit hart with a CSR port addressed by 12-bit CSR numbers.
`ifndef SUPTU_CONSTS_SVH
`define SUPTU_CONSTS_SVH

// ==========================================================================
// CSR numbers
`define SUPTU_CSR_STATUS   12'h100
`define SUPTU_CSR_ENABLE   12'h104
`define SUPTU_CSR_VECTOR   12'h105
`define SUPTU_CSR_EPC      12'h141
`define SUPTU_CSR_CAUSE    12'h142
`define SUPTU_CSR_PENDING  12'h144
`define SUPTU_CSR_IDELEG   12'h303
`define SUPTU_CSR_EDELEG   12'h302

// ==========================================================================
// Field positions
`define SUPTU_BIT_SIE      1
`define SUPTU_BIT_SUP_PRIOR_INT_ENABLE     5
`define SUPTU_BIT_SPP      8
`define SUPTU_BIT_SW       1
`define SUPTU_BIT_TIMER    5
`define SUPTU_BIT_EXT      9
`define SUPTU_BIT_INTR     63
`define SUPTU_PEND_MASK    64'h0000_0000_0000_0222
`define SUPTU_EDELEG_MASK  64'h0000_0000_0000_B1EF

// ==========================================================================
// Codes and modes
`define SUPTU_CODE_SW      63'h1
`define SUPTU_CODE_TIMER   63'h5
`define SUPTU_CODE_EXT     63'h9
`define SUPTU_MODE_DIRECT  2'h0
`define SUPTU_MODE_VECTOR  2'h1
`define SUPTU_RESET_VALUE  64'h0000_0000_0000_0000

`endif

// >>> pkg/suptu_pkg.sv
// Types of the supervisor trap unit.
// Assumes suptu_consts.svh supplies the numeric constants.
package suptu_pkg;

    // ======================================================================
    // Trap request from the pipeline
    typedef struct packed {
        logic        valid;
        logic        is_intr;
        logic [62:0] code;
        logic [63:0] pc;
        logic        priv;
    } suptu_trap_type;

    // ======================================================================
    // CSR access from software
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [63:0] wdata;
    } suptu_csr_type;

    typedef enum logic [1:0] {
        SUPTU_RUN,
        SUPTU_TRAP,
        SUPTU_RET
    } suptu_event_type;

endpackage : suptu_pkg

// >>> logic/suptu_vector.sv
// Handler address computation for direct and vectored trap entry.
// Assumes base is stored without its two low bits.
`timescale 1ns/1ps
`include "suptu_consts.svh"
module suptu_vector (
    // Vector register fields
    input  wire logic [61:0] base_i,
    input  wire logic [1:0]  mode_i,
    // Trap description
    input  wire logic        is_intr_i,
    input  wire logic [62:0] code_i,
    // Result
    output logic [63:0]      target_o
);
    logic [63:0] base_addr;

    assign base_addr = {base_i, 2'h0};
    // Only interrupts are offset; exceptions always land on base
    assign target_o = (mode_i == `SUPTU_MODE_VECTOR && is_intr_i)
                      ? base_addr + {code_i[61:0], 2'h0}
                      : base_addr;
endmodule : suptu_vector

// >>> logic/suptu_irq_select.sv
// Picks the supervisor interrupt to take, external over software over timer.
// Assumes pending and enable are masked to the three implemented bits.
`timescale 1ns/1ps
`include "suptu_consts.svh"
module suptu_irq_select (
    // Gating inputs
    input  wire logic [63:0] pending_i,
    input  wire logic [63:0] enable_i,
    input  wire logic [63:0] ideleg_i,
    input  wire logic        global_en_i,
    // Selection
    output logic             take_o,
    output logic [62:0]      code_o
);
    logic [63:0] ready;

    assign ready = pending_i & enable_i & ideleg_i & `SUPTU_PEND_MASK;
    always_comb begin
        take_o = global_en_i && (ready != 64'h0);
        if (ready[`SUPTU_BIT_EXT]) begin
            code_o = `SUPTU_CODE_EXT;
        end else if (ready[`SUPTU_BIT_SW]) begin
            code_o = `SUPTU_CODE_SW;
        end else begin
            code_o = `SUPTU_CODE_TIMER;
        end
    end
endmodule : suptu_irq_select

// >>> logic/suptu_top.sv
// Supervisor trap unit: pending, cause, vector, status bits, trap entry/return.
// Assumes the pipeline raises one trap or return request at a time.
//
// Contract
// - Pending flags at bits 1, 5, 9 only
// - Taking a trap loads the cause register
// - Interrupt cause sets bit 63, number below
// - Exception cause clears bit 63
// - Cause holds code 62:0, flag 63
// - Interrupt codes 1, 5, 9
// - Exception codes as listed, others reserved
// - External interrupts use code 9, offset 0x24
// - Vector base bits 63:2, low bits zero
// - Mode 0 direct, mode 1 vectors interrupts
// - Trap saves enable to prior, clears enable
// - Trap saves pc, redirects to vector
// - Trap records prior privilege
// - Software setting enable re-enables interrupts
// - Return restores privilege from prior privilege
// - Return copies prior enable to enable
// - Return loads pc from saved pc
// - Status bits 1, 5, 8 read-write
// - Interrupt needs global and individual enable
// - Only delegated traps come here
`timescale 1ns/1ps
`include "suptu_consts.svh"
module suptu_top (
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    reset_i,
    // Pipeline
    input  wire suptu_pkg::suptu_trap_type exc_i,
    input  wire logic                    sup_trap_return_i,
    // Interrupt sources
    input  wire logic                    timer_src_i,
    input  wire logic                    ext_src_i,
    // CSR port
    input  wire suptu_pkg::suptu_csr_type csr_i,
    output logic [63:0]                  csr_rdata_o,
    // Redirect
    output logic                         redirect_o,
    output logic [63:0]                  redirect_pc_o,
    output logic                         priv_o,
    output logic                         global_en_o
);
    // ======================================================================
    // State
    logic [63:0] sup_pending_flags_r;
    logic [63:0] sup_trap_cause_r;
    logic [61:0] vec_base_r;
    logic [1:0]  vec_mode_r;
    logic [63:0] epc_r;
    logic [63:0] enable_r;
    logic [63:0] ideleg_r;
    logic [63:0] edeleg_r;
    logic        sie_r;
    logic        sup_prior_int_enable_r;
    logic        sup_prior_privilege_r;
    logic        priv_r;
    logic        redirect_r;
    logic [63:0] redirect_pc_r;
    logic [63:0] csr_rdata_r;

    logic        irq_take;
    logic [62:0] irq_code;
    logic        exc_take;
    logic        trap_go;
    logic        trap_intr;
    logic [62:0] trap_code;
    logic [63:0] trap_target;
    logic [63:0] pending_view;
    logic [63:0] status_view;
    suptu_pkg::suptu_event_type ev;

    function automatic logic wr_hit(input suptu_pkg::suptu_csr_type c, input logic [11:0] a);
        wr_hit = c.wr && (c.addr == a);
    endfunction : wr_hit

    // ======================================================================
    // Trap arbitration
    // Hardware sources land in pending bits; sources OR with software copy
    assign pending_view = sup_pending_flags_r
                          | ({54'h0, ext_src_i, 3'h0, timer_src_i, 5'h0});

    suptu_irq_select u_sel (
        .pending_i   (pending_view),
        .enable_i    (enable_r),
        .ideleg_i    (ideleg_r),
        .global_en_i (sie_r),
        .take_o      (irq_take),
        .code_o      (irq_code)
    );

    // Exceptions only when delegated; exceptions beat interrupts, interrupts beat returns
    // Delegation bits hold only implemented codes, so reserved codes never trap
    assign exc_take  = exc_i.valid && !exc_i.is_intr && (exc_i.code[62:6] == 57'h0)
                       && edeleg_r[exc_i.code[5:0]];
    assign trap_go   = exc_take || irq_take;
    assign trap_intr = !exc_take;
    assign trap_code = exc_take ? exc_i.code : irq_code;

    always_comb begin
        if (trap_go) begin
            ev = suptu_pkg::SUPTU_TRAP;
        end else if (sup_trap_return_i) begin
            ev = suptu_pkg::SUPTU_RET;
        end else begin
            ev = suptu_pkg::SUPTU_RUN;
        end
    end

    suptu_vector u_vec (
        .base_i    (vec_base_r),
        .mode_i    (vec_mode_r),
        .is_intr_i (trap_intr),
        .code_i    (trap_code),
        .target_o  (trap_target)
    );

    // ======================================================================
    // Pending register: only three flags writable
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sup_pending_flags_r <= `SUPTU_RESET_VALUE;
        end else if (wr_hit(csr_i, `SUPTU_CSR_PENDING)) begin
            sup_pending_flags_r <= csr_i.wdata & `SUPTU_PEND_MASK;
        end
    end

    // ======================================================================
    // Cause register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sup_trap_cause_r <= `SUPTU_RESET_VALUE;
        end else if (ev == suptu_pkg::SUPTU_TRAP) begin
            sup_trap_cause_r <= {trap_intr, trap_code};
        end else if (wr_hit(csr_i, `SUPTU_CSR_CAUSE)) begin
            sup_trap_cause_r <= csr_i.wdata;
        end
    end

    // ======================================================================
    // Vector register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            vec_base_r <= 62'h0;
            vec_mode_r <= `SUPTU_MODE_DIRECT;
        end else if (wr_hit(csr_i, `SUPTU_CSR_VECTOR)) begin
            vec_base_r <= csr_i.wdata[63:2];
            // Reserved modes are dropped so the field only reads 0 or 1
            if (csr_i.wdata[1:0] <= `SUPTU_MODE_VECTOR) begin
                vec_mode_r <= csr_i.wdata[1:0];
            end
        end
    end

    // ======================================================================
    // Saved pc, enable and delegation registers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            epc_r <= `SUPTU_RESET_VALUE;
        end else if (ev == suptu_pkg::SUPTU_TRAP) begin
            epc_r <= exc_take ? exc_i.pc : exc_i.pc;
        end else if (wr_hit(csr_i, `SUPTU_CSR_EPC)) begin
            epc_r <= csr_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            enable_r <= `SUPTU_RESET_VALUE;
            ideleg_r <= `SUPTU_RESET_VALUE;
            edeleg_r <= `SUPTU_RESET_VALUE;
        end else begin
            if (wr_hit(csr_i, `SUPTU_CSR_ENABLE)) begin
                enable_r <= csr_i.wdata & `SUPTU_PEND_MASK;
            end
            if (wr_hit(csr_i, `SUPTU_CSR_IDELEG)) begin
                ideleg_r <= csr_i.wdata & `SUPTU_PEND_MASK;
            end
            if (wr_hit(csr_i, `SUPTU_CSR_EDELEG)) begin
                edeleg_r <= csr_i.wdata & `SUPTU_EDELEG_MASK;
            end
        end
    end

    // ======================================================================
    // Status bits and privilege
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sie_r                  <= 1'b0;
            sup_prior_int_enable_r <= 1'b0;
            sup_prior_privilege_r  <= 1'b0;
            priv_r                 <= 1'b1;
        end else begin
            case (ev)
                suptu_pkg::SUPTU_TRAP: begin
                    sup_prior_int_enable_r <= sie_r;
                    sie_r                  <= 1'b0;
                    sup_prior_privilege_r  <= exc_i.priv;
                    priv_r                 <= 1'b1;
                end
                suptu_pkg::SUPTU_RET: begin
                    priv_r <= sup_prior_privilege_r;
                    sie_r  <= sup_prior_int_enable_r;
                end
                default: begin
                    if (wr_hit(csr_i, `SUPTU_CSR_STATUS)) begin
                        sie_r                  <= csr_i.wdata[`SUPTU_BIT_SIE];
                        sup_prior_int_enable_r <= csr_i.wdata[`SUPTU_BIT_SUP_PRIOR_INT_ENABLE];
                        sup_prior_privilege_r  <= csr_i.wdata[`SUPTU_BIT_SPP];
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // Redirect
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            redirect_r    <= 1'b0;
            redirect_pc_r <= `SUPTU_RESET_VALUE;
        end else begin
            redirect_r <= (ev != suptu_pkg::SUPTU_RUN);
            if (ev == suptu_pkg::SUPTU_TRAP) begin
                redirect_pc_r <= trap_target;
            end else if (ev == suptu_pkg::SUPTU_RET) begin
                redirect_pc_r <= epc_r;
            end
        end
    end

    // ======================================================================
    // Read data, registered one cycle after address
    always_comb begin
        status_view = 64'h0;
        status_view[`SUPTU_BIT_SIE]  = sie_r;
        status_view[`SUPTU_BIT_SUP_PRIOR_INT_ENABLE] = sup_prior_int_enable_r;
        status_view[`SUPTU_BIT_SPP]  = sup_prior_privilege_r;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            csr_rdata_r <= `SUPTU_RESET_VALUE;
        end else begin
            case (csr_i.addr)
                `SUPTU_CSR_STATUS:  csr_rdata_r <= status_view;
                `SUPTU_CSR_ENABLE:  csr_rdata_r <= enable_r;
                `SUPTU_CSR_VECTOR:  csr_rdata_r <= {vec_base_r, vec_mode_r};
                `SUPTU_CSR_EPC:     csr_rdata_r <= epc_r;
                `SUPTU_CSR_CAUSE:   csr_rdata_r <= sup_trap_cause_r;
                `SUPTU_CSR_PENDING: csr_rdata_r <= pending_view;
                `SUPTU_CSR_IDELEG:  csr_rdata_r <= ideleg_r;
                `SUPTU_CSR_EDELEG:  csr_rdata_r <= edeleg_r;
                default:            csr_rdata_r <= 64'h0;
            endcase
        end
    end

    assign csr_rdata_o   = csr_rdata_r;
    assign redirect_o    = redirect_r;
    assign redirect_pc_o = redirect_pc_r;
    assign priv_o        = priv_r;
    assign global_en_o   = sie_r;
endmodule : suptu_top

// >>> verification/suptu_assertions.sv
// Port checker for the supervisor trap unit.
// Assumes software reaches the unit only through csr_i.
`timescale 1ns/1ps
`include "suptu_consts.svh"
module suptu_assertions (
    // Clock and reset
    input wire logic                      ref_clk_i,
    input wire logic                      reset_i,
    // Requests
    input wire suptu_pkg::suptu_trap_type exc_i,
    input wire logic                      sup_trap_return_i,
    input wire suptu_pkg::suptu_csr_type  csr_i,
    // Results
    input wire logic [63:0]               csr_rdata_o,
    input wire logic                      redirect_o,
    input wire logic [63:0]               redirect_pc_o,
    input wire logic                      global_en_o
);
    // ==========================================================================
    // Shadows of vector and saved pc
    logic [63:0] vec_r;
    logic [63:0] epc_r;
    logic [63:0] pc_q;
    logic        ret_q;
    wire logic [63:0] base_w = {vec_r[63:2], 2'h0};
    // A redirect not preceded by a return request is a trap entry
    wire logic trap_w = redirect_o && !ret_q;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ret_q <= 1'b0;
            pc_q  <= 64'h0;
        end else begin
            ret_q <= sup_trap_return_i;
            pc_q  <= exc_i.pc;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            vec_r <= 64'h0;
        end else if (csr_i.wr && csr_i.addr == `SUPTU_CSR_VECTOR) begin
            vec_r <= {csr_i.wdata[63:2], csr_i.wdata[1] ? vec_r[1:0] : csr_i.wdata[1:0]};
        end
    end
    // Capture lags the unit by one edge, so a later software write must win
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            epc_r <= 64'h0;
        end else if (csr_i.wr && csr_i.addr == `SUPTU_CSR_EPC) begin
            epc_r <= csr_i.wdata;
        end else if (trap_w) begin
            epc_r <= pc_q;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================================================
    // Properties
    property p_pend_rsvd;
        $past(csr_i.addr) == `SUPTU_CSR_PENDING |-> (csr_rdata_o & ~`SUPTU_PEND_MASK) == 64'h0;
    endproperty
    a_pend_rsvd: assert property (p_pend_rsvd) else $error("pending reserved bits set");
    property p_vec_mode;
        $past(csr_i.addr) == `SUPTU_CSR_VECTOR |-> !csr_rdata_o[1];
    endproperty
    a_vec_mode: assert property (p_vec_mode) else $error("vector mode illegal");
    property p_trap_en_off;
        trap_w |-> !global_en_o;
    endproperty
    a_trap_en_off: assert property (p_trap_en_off) else $error("enable kept on trap");
    property p_ret_pc;
        sup_trap_return_i && !exc_i.valid && !global_en_o |=> redirect_o && redirect_pc_o == epc_r;
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return target wrong");
    property p_exc_base;
        trap_w && $past(exc_i.valid) && !$past(global_en_o) |-> redirect_pc_o == base_w;
    endproperty
    a_exc_base: assert property (p_exc_base) else $error("exception target wrong");
    property p_intr_vec;
        trap_w && !$past(exc_i.valid) |->
            (vec_r[0] ? (redirect_pc_o - base_w) inside {64'h4, 64'h14, 64'h24}
                      : redirect_pc_o == base_w);
    endproperty
    a_intr_vec: assert property (p_intr_vec) else $error("interrupt target wrong");
    property p_en_gate;
        trap_w && !$past(exc_i.valid) |-> $past(global_en_o);
    endproperty
    a_en_gate: assert property (p_en_gate) else $error("interrupt while disabled");
    property p_undeleg;
        exc_i.valid && exc_i.code == 63'h4 && !global_en_o && !sup_trap_return_i |=> !redirect_o;
    endproperty
    a_undeleg: assert property (p_undeleg) else $error("reserved code trapped");
    c_ret: cover property (sup_trap_return_i ##1 redirect_o);
    c_exc: cover property (exc_i.valid ##1 redirect_o);
    c_intr: cover property (trap_w && vec_r[0] && !$past(exc_i.valid));
endmodule : suptu_assertions

// >>> verification/suptu_src_model.sv
// Interrupt source model: level lines seen as pending by the unit.
// Assumes the bench calls set_src from its own process.
`timescale 1ns/1ps
module suptu_src_model (
    // Clock
    input  wire logic ref_clk_i,
    // Level sources
    output logic      timer_src_o,
    output logic      ext_src_o
);
    initial begin
        timer_src_o = 1'b0;
        ext_src_o   = 1'b0;
    end
    // Change only after an edge, as a real peripheral does
    task automatic set_src(input logic t, input logic e);
        @(posedge ref_clk_i);
        timer_src_o <= t;
        ext_src_o   <= e;
    endtask : set_src
endmodule : suptu_src_model

// >>> verification/testbench.sv
// Self-checking bench for the supervisor trap unit.
// Assumes suptu_top, the source model and the checker are compiled first.
`timescale 1ns/1ps
`include "suptu_consts.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
    logic                      ref_clk_i;
    logic                      reset_i;
    suptu_pkg::suptu_trap_type exc_i;
    logic                      sup_ret;
    suptu_pkg::suptu_csr_type  csr_i;
    logic [63:0]               rdata;
    logic [63:0]               rpc;
    logic                      redir;
    logic                      priv;
    logic                      gen;
    logic                      timer;
    logic                      ext;
    int                        fail_count;
    int                        samples_checked;
    suptu_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .exc_i(exc_i),
        .sup_trap_return_i(sup_ret), .timer_src_i(timer), .ext_src_i(ext), .csr_i(csr_i),
        .csr_rdata_o(rdata), .redirect_o(redir), .redirect_pc_o(rpc), .priv_o(priv),
        .global_en_o(gen));
    suptu_src_model i_src (.ref_clk_i(ref_clk_i), .timer_src_o(timer), .ext_src_o(ext));
    // ==========================================================================
    // Bus tasks
    task automatic csr_wr(input logic [11:0] a, input logic [63:0] d);
        @(posedge ref_clk_i);
        csr_i <= {1'b1, a, d};
        @(posedge ref_clk_i);
        csr_i.wr <= 1'b0;
    endtask : csr_wr
    task automatic csr_chk(input string n, input logic [11:0] a, input logic [63:0] e);
        @(posedge ref_clk_i);
        csr_i <= {1'b0, a, 64'h0};
        @(posedge ref_clk_i);
        #1;
        `CHK(n, e, rdata)
    endtask : csr_chk
    task automatic trap(input logic [62:0] c, input logic [63:0] pc, input logic r);
        @(posedge ref_clk_i);
        exc_i <= {1'b1, 1'b0, c, pc, 1'b1};
        @(posedge ref_clk_i);
        exc_i <= '0;
        #1;
        `CHK("trap redirect", r, redir)
        if (r) `CHK("trap target", 64'h1000, rpc)
    endtask : trap
    // ==========================================================================
    // Scenarios
    task automatic t_regs();
        csr_wr(`SUPTU_CSR_PENDING, '1);
        csr_chk("pending", `SUPTU_CSR_PENDING, 64'h222);
        csr_wr(`SUPTU_CSR_PENDING, 64'h0);
        csr_wr(`SUPTU_CSR_VECTOR, 64'h1001);
        csr_wr(`SUPTU_CSR_VECTOR, 64'h1002);
        csr_chk("vector", `SUPTU_CSR_VECTOR, 64'h1001);
    endtask : t_regs
    task automatic t_exc();
        logic [62:0] codes[11] = '{0, 1, 2, 3, 5, 6, 7, 8, 12, 13, 15};
        csr_wr(`SUPTU_CSR_EDELEG, '1);
        csr_wr(`SUPTU_CSR_STATUS, 64'h2);
        foreach (codes[i]) begin
            trap(codes[i], 64'h100 + i, 1'b1);
            csr_chk("cause", `SUPTU_CSR_CAUSE, {1'b0, codes[i]});
            if (i == 0) csr_chk("status", `SUPTU_CSR_STATUS, 64'h120);
        end
        csr_chk("epc", `SUPTU_CSR_EPC, 64'h10A);
        trap(63'h4, 64'h0, 1'b0);
        csr_wr(`SUPTU_CSR_STATUS, 64'h020);
        csr_chk("status rw", `SUPTU_CSR_STATUS, 64'h020);
        @(posedge ref_clk_i);
        sup_ret <= 1'b1;
        @(posedge ref_clk_i);
        sup_ret <= 1'b0;
        #1;
        `CHK("ret target", 64'h10A, rpc)
        `CHK("ret priv", 1'b0, priv)
        `CHK("ret enable", 1'b1, gen)
    endtask : t_exc
    task automatic t_intr();
        logic [62:0] codes[3] = '{9, 1, 5};
        int m;
        int j;
        csr_wr(`SUPTU_CSR_ENABLE, 64'h222);
        csr_wr(`SUPTU_CSR_IDELEG, 64'h222);
        for (m = 0; m < 2; m++) begin
            csr_wr(`SUPTU_CSR_VECTOR, 64'h1000 | m);
            foreach (codes[k]) begin
                csr_wr(`SUPTU_CSR_STATUS, 64'h0);
                if (k == 1) csr_wr(`SUPTU_CSR_PENDING, 64'h2);
                else i_src.set_src(k == 2, k == 0);
                repeat (3) @(posedge ref_clk_i);
                #1;
                `CHK("held", 1'b0, redir)
                csr_wr(`SUPTU_CSR_STATUS, 64'h2);
                for (j = 0; j < 8 && redir !== 1'b1; j++) begin
                    @(posedge ref_clk_i);
                    #1;
                end
                `CHK("intr target", 64'h1000 + (m ? 4 * codes[k] : 0), rpc)
                csr_chk("intr cause", `SUPTU_CSR_CAUSE, {1'b1, codes[k]});
                i_src.set_src(1'b0, 1'b0);
                csr_wr(`SUPTU_CSR_PENDING, 64'h0);
            end
        end
    endtask : t_intr
    task automatic test_done();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        test_done();
    end
    initial begin
        reset_i = 1'b1;
        exc_i = '0;
        sup_ret = 1'b0;
        csr_i = '0;
        repeat (5) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_exc();
        t_intr();
        test_done();
    end
endmodule : testbench
bind suptu_top suptu_assertions i_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .exc_i(exc_i), .sup_trap_return_i(sup_trap_return_i), .csr_i(csr_i),
    .csr_rdata_o(csr_rdata_o), .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o),
    .global_en_o(global_en_o));
